//--- core/dbmc_pkg.sv
// Shared constants and helpers for the DRAM bank map configuration block
package dbmc_pkg;

    // Register indices seen through the extended setup access
    localparam logic [15:0] IDX_CHIP_SIZE = 16'h0181;
    localparam logic [15:0] IDX_UPPER_ENABLE = 16'h0182;
    localparam logic [15:0] IDX_WINDOW0 = 16'h0184;
    localparam logic [15:0] IDX_WINDOW1 = 16'h0185;
    localparam logic [15:0] IDX_WINDOW2 = 16'h0186;
    localparam logic [15:0] IDX_WINDOW3 = 16'h0187;

    // Values after reset
    localparam logic [7:0] RST_CHIP_SIZE = 8'h00;
    localparam logic [3:0] RST_UPPER_ENABLE = 4'hf;
    localparam logic [5:0] RST_WINDOW0 = 6'h00;
    localparam logic [5:0] RST_WINDOW1 = 6'h01;
    localparam logic [5:0] RST_WINDOW2 = 6'h02;
    localparam logic [5:0] RST_WINDOW3 = 6'h03;

    // Field positions
    localparam int BANK2_EN_LSB = 0;
    localparam int BANK3_EN_LSB = 2;
    localparam int WIN_ADDR_LSB = 20;
    localparam int WIN_ADDR_MSB = 25;
    localparam int MAP_TOP_LSB = 26;

    // Bank enable codes
    localparam logic [1:0] EN_CODE_ON = 2'h0;
    localparam logic [1:0] EN_CODE_OFF = 2'h3;

    // Chip size codes
    localparam logic [1:0] SIZE_256K = 2'h0;
    localparam logic [1:0] SIZE_RSVD = 2'h1;
    localparam logic [1:0] SIZE_1M = 2'h2;
    localparam logic [1:0] SIZE_4M = 2'h3;

    // Window bits that take part in the compare for a given chip size
    function automatic logic [5:0] sizeMask(input logic [1:0] code);
        case (code)
            SIZE_256K: sizeMask = 6'h3f;
            SIZE_1M: sizeMask = 6'h3c;
            SIZE_4M: sizeMask = 6'h30;
            default: sizeMask = 6'h00;
        endcase
    endfunction

    // A bank is usable only while its enable field holds the on code
    function automatic logic enCodeOn(input logic [1:0] code);
        enCodeOn = (code == EN_CODE_ON);
    endfunction

endpackage

//--- core/dbmc_bank_match.sv
// Address compare of one DRAM bank against its window base
`timescale 1ns/10ps
module dbmc_bank_match (
    // Access address
    input wire logic [31:0] addr,
    // Bank configuration
    input wire logic [5:0] windowBase,
    input wire logic [1:0] sizeCode,
    input wire logic enable,
    // Result
    output logic hit
);
    // Only bits significant for the chip size are compared; nothing above 64 MB
    wire [5:0] mask = dbmc_pkg::sizeMask(sizeCode); // RQ9
    wire [5:0] addrWin = addr[dbmc_pkg::WIN_ADDR_MSB:dbmc_pkg::WIN_ADDR_LSB]; // RQ10
    wire inRange = (addr[31:dbmc_pkg::MAP_TOP_LSB] == 6'h00); // RQ10
    wire reservedSize = (sizeCode == dbmc_pkg::SIZE_RSVD);

    // Reserved size code never matches
    assign hit = enable && inRange && !reservedSize
        && (((addrWin ^ windowBase) & mask) == 6'h00); // RQ16

endmodule // dbmc_bank_match

//--- core/dbmc_bank_pick.sv
// Registered bank selection from the four bank compare results
`timescale 1ns/10ps
module dbmc_bank_pick (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Compare results
    input wire logic memReq,
    input wire logic [3:0] hits,
    input wire logic [7:0] chipSizes,
    // Selection
    output logic [3:0] bankSelect,
    output logic bankHit,
    output logic [1:0] bankChipSize
);
    // Lowest numbered matching bank wins, so overlaps cannot select two
    wire [3:0] oneHot = hits & (~hits + 4'h1); // RQ16
    wire [1:0] pickIdx = oneHot[1] ? 2'h1 : oneHot[2] ? 2'h2 : oneHot[3] ? 2'h3 : 2'h0;
    wire [3:0] next_select = memReq ? oneHot : 4'h0;
    wire [1:0] next_size = chipSizes[{pickIdx, 1'b0} +: 2];

    // Selection registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            bankSelect <= 4'h0;
            bankHit <= 1'b0;
            bankChipSize <= 2'h0;
        end else begin
            bankSelect <= next_select;
            bankHit <= |next_select;
            bankChipSize <= (|next_select) ? next_size : 2'h0;
        end
    end

endmodule // dbmc_bank_pick

//--- core/dbmc_bank_map.sv
// DRAM bank map configuration registers and bank selection
`timescale 1ns/10ps
// Notes on behaviour
// [RQ1] Bank 2 enable field bits 1:0; 00 enables, 11 disables, others reserved.
// [RQ2] Bank 3 enable field bits 3:2; 00 enables, 11 disables, others reserved.
// [RQ3] Enable register resets to 0x0f, upper bits reserved, readable and writable.
// [RQ4] Size register holds a two-bit chip code per bank, bank 0 lowest.
// [RQ5] Chip size codes steer which address bits pick a bank.
// [RQ6] Size register fully readable and writable, resets to all zeros.
// [RQ7] Software places larger chips in lower banks.
// [RQ8] Software uses page mode only with equal chip sizes in all banks.
// [RQ9] Window granule is 1, 4 or 16 MB by chip size.
// [RQ10] Window bits 5:0 map address bits 25:20; bits 7:6 reserved.
// [RQ11] Software programs only the window bits significant for the size.
// [RQ12] Windows reset to 0, 1, 2 and 3.
// [RQ13] Software keeps bank windows unique and non-overlapping.
// [RQ14] Software keeps board memory contiguous from address zero.
// [RQ15] Registers answer only through the extended setup access.
// [RQ16] Enabled bank whose significant window bits match is selected, else none.
// [RQ17] A disabled bank is never selected.
module dbmc_bank_map (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Extended setup register access
    input wire logic extendedSetupAccess,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regIndex,
    input wire logic [7:0] regWriteData,
    output logic [7:0] regReadData,
    output logic regReadValid,
    // Memory access decode
    input wire logic memReq,
    input wire logic [31:0] memAddr,
    output logic [3:0] bankSelect,
    output logic bankHit,
    output logic [1:0] bankChipSize
);
    // Configuration storage
    logic [7:0] bankChipSizeReg;
    logic [3:0] bankUpperEnable;
    logic [5:0] windowBase [4];

    // Access qualification: nothing moves without the extended setup access
    wire accWrite = extendedSetupAccess && regWrite; // RQ15
    wire accRead = extendedSetupAccess && regRead; // RQ15

    // Register decode
    wire selSize = (regIndex == dbmc_pkg::IDX_CHIP_SIZE);
    wire selEnable = (regIndex == dbmc_pkg::IDX_UPPER_ENABLE);
    wire [3:0] selWindow = {regIndex == dbmc_pkg::IDX_WINDOW3,
        regIndex == dbmc_pkg::IDX_WINDOW2,
        regIndex == dbmc_pkg::IDX_WINDOW1,
        regIndex == dbmc_pkg::IDX_WINDOW0};

    // Per bank enables: banks 0 and 1 have no enable here and stay on
    wire [1:0] bank2Code = bankUpperEnable[dbmc_pkg::BANK2_EN_LSB +: 2];
    wire [1:0] bank3Code = bankUpperEnable[dbmc_pkg::BANK3_EN_LSB +: 2];
    wire bank2On = dbmc_pkg::enCodeOn(bank2Code); // RQ1 RQ17
    wire bank3On = dbmc_pkg::enCodeOn(bank3Code); // RQ2 RQ17
    wire [3:0] bankOn = {bank3On, bank2On, 1'b1, 1'b1};

    // Read multiplexer; reserved bits and unmapped indices read zero
    wire [7:0] next_readData = selSize ? bankChipSizeReg
        : selEnable ? {4'h0, bankUpperEnable}
        : selWindow[0] ? {2'h0, windowBase[0]}
        : selWindow[1] ? {2'h0, windowBase[1]}
        : selWindow[2] ? {2'h0, windowBase[2]}
        : selWindow[3] ? {2'h0, windowBase[3]}
        : 8'h00;

    // Chip size and enable registers
    always_ff @(posedge mclk) begin
        if (reset) begin
            bankChipSizeReg <= dbmc_pkg::RST_CHIP_SIZE; // RQ6
            bankUpperEnable <= dbmc_pkg::RST_UPPER_ENABLE; // RQ3
        end else begin
            if (accWrite && selSize) begin
                bankChipSizeReg <= regWriteData; // RQ4 RQ6
            end
            if (accWrite && selEnable) begin
                bankUpperEnable <= regWriteData[3:0]; // RQ3
            end
        end
    end

    // Window base registers; bits 7:6 are not stored
    always_ff @(posedge mclk) begin
        if (reset) begin
            windowBase[0] <= dbmc_pkg::RST_WINDOW0; // RQ12
            windowBase[1] <= dbmc_pkg::RST_WINDOW1; // RQ12
            windowBase[2] <= dbmc_pkg::RST_WINDOW2; // RQ12
            windowBase[3] <= dbmc_pkg::RST_WINDOW3; // RQ12
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (accWrite && selWindow[i]) begin
                    windowBase[i] <= regWriteData[5:0]; // RQ10
                end
            end
        end
    end

    // Read answer, one cycle after the read strobe
    always_ff @(posedge mclk) begin
        if (reset) begin
            regReadData <= 8'h00;
            regReadValid <= 1'b0;
        end else begin
            regReadValid <= accRead; // RQ15
            regReadData <= accRead ? next_readData : 8'h00;
        end
    end

    // Per bank address compare
    wire [3:0] hits;
    for (genvar b = 0; b < 4; b++) begin : g_match
        dbmc_bank_match u_match (
            .addr(memAddr),
            .windowBase(windowBase[b]),
            .sizeCode(bankChipSizeReg[2 * b +: 2]), // RQ5
            .enable(bankOn[b]), // RQ17
            .hit(hits[b])
        );
    end

    // Bank selection register stage
    dbmc_bank_pick u_pick (
        .mclk(mclk),
        .reset(reset),
        .memReq(memReq),
        .hits(hits),
        .chipSizes(bankChipSizeReg),
        .bankSelect(bankSelect),
        .bankHit(bankHit),
        .bankChipSize(bankChipSize)
    );

    // Checks on configuration and selection
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (reset);

    sequence s_size_write;
        accWrite && selSize;
    endsequence

    sequence s_size_read;
        accRead && selSize;
    endsequence

    property p_bank2_off;
        (memReq && bank2Code != dbmc_pkg::EN_CODE_ON) |=> !bankSelect[2];
    endproperty
    a_bank2_off: assert property (p_bank2_off) // RQ1
        else $error("bank 2 selected while not enabled");

    property p_bank3_off;
        (memReq && bank3Code == dbmc_pkg::EN_CODE_OFF) |=> !bankSelect[3];
    endproperty
    a_bank3_off: assert property (p_bank3_off) // RQ2
        else $error("bank 3 selected while disabled");

    property p_enable_reset;
        $past(reset) |-> (bankUpperEnable == 4'hf && !bank2On && !bank3On);
    endproperty
    a_enable_reset: assert property (p_enable_reset) // RQ3
        else $error("bank enable register not 0x0f after reset");

    property p_size_roundtrip;
        logic [7:0] d;
        (s_size_write, d = regWriteData) ##1 (!accWrite)[*2] ##0 s_size_read
            |=> (regReadValid && regReadData == d);
    endproperty
    a_size_roundtrip: assert property (p_size_roundtrip) // RQ6
        else $error("size register read differs from value written");

    property p_size_4m_granule;
        (memReq && bankChipSizeReg[1:0] == dbmc_pkg::SIZE_4M
            && memAddr[31:26] == 6'h00 && memAddr[25:24] == windowBase[0][5:4])
            |=> (bankSelect == 4'h1 && bankChipSize == dbmc_pkg::SIZE_4M);
    endproperty
    a_size_4m_granule: assert property (p_size_4m_granule) // RQ9
        else $error("4M bank 0 not selected on 16 MB window match");

    property p_above_map;
        (memReq && memAddr[31:26] != 6'h00) |=> !bankHit;
    endproperty
    a_above_map: assert property (p_above_map) // RQ10
        else $error("bank selected above 64 MB");

    property p_window_reset;
        $past(reset) |-> (windowBase[1] == 6'h01 && windowBase[3] == 6'h03);
    endproperty
    a_window_reset: assert property (p_window_reset) // RQ12
        else $error("window bases wrong after reset");

    property p_no_access_outside;
        !extendedSetupAccess |=> (!regReadValid && $stable(bankChipSizeReg)
            && $stable(bankUpperEnable));
    endproperty
    a_no_access_outside: assert property (p_no_access_outside) // RQ15
        else $error("register access without extended setup access");

    property p_one_bank;
        bankHit |-> ($onehot(bankSelect) && $past(memReq));
    endproperty
    a_one_bank: assert property (p_one_bank) // RQ16
        else $error("bank selection not one-hot or without request");

    property p_bank0_base;
        (memReq && bankChipSizeReg[1:0] == dbmc_pkg::SIZE_256K
            && memAddr[31:20] == {6'h00, windowBase[0]}) |=> bankSelect[0];
    endproperty
    a_bank0_base: assert property (p_bank0_base) // RQ5
        else $error("bank 0 missed on exact 1 MB window match");

    property p_disabled_never;
        (memReq && !bank3On) ##1 1'b1 |-> !bankSelect[3] && !(bankHit && bankSelect == 4'h8);
    endproperty
    a_disabled_never: assert property (p_disabled_never) // RQ17
        else $error("disabled bank 3 selected");

    // Enable, size, window and access checks
    property p_bank2_on;
        (memReq && bank2On && hits[1:0] == 2'h0
            && bankChipSizeReg[5:4] == dbmc_pkg::SIZE_256K
            && memAddr[31:20] == {6'h00, windowBase[2]}) |=> bankSelect == 4'h4;
    endproperty
    a_bank2_on: assert property (p_bank2_on) // RQ1
        else $error("enabled bank 2 missed on its window");

    property p_bank3_on;
        (memReq && bank3On && hits[2:0] == 3'h0
            && bankChipSizeReg[7:6] == dbmc_pkg::SIZE_256K
            && memAddr[31:20] == {6'h00, windowBase[3]}) |=> bankSelect == 4'h8;
    endproperty
    a_bank3_on: assert property (p_bank3_on) // RQ2
        else $error("enabled bank 3 missed on its window");

    property p_enable_write;
        logic [3:0] v;
        (accWrite && selEnable, v = regWriteData[3:0]) |=> bankUpperEnable == v;
    endproperty
    a_enable_write: assert property (p_enable_write) // RQ3
        else $error("enable register did not take the written value");

    property p_enable_read;
        (accRead && selEnable) |=> (regReadValid && regReadData[7:4] == 4'h0);
    endproperty
    a_enable_read: assert property (p_enable_read) // RQ3
        else $error("enable register reserved bits not zero on read");

    property p_size_lane;
        logic [1:0] s;
        (memReq && hits[1:0] == 2'h2, s = bankChipSizeReg[3:2])
            |=> (bankSelect == 4'h2 && bankChipSize == s);
    endproperty
    a_size_lane: assert property (p_size_lane) // RQ4
        else $error("bank 1 size code not taken from bits 3:2");

    property p_reserved_size;
        (memReq && bankChipSizeReg[3:2] == dbmc_pkg::SIZE_RSVD) |=> !bankSelect[1];
    endproperty
    a_reserved_size: assert property (p_reserved_size) // RQ4
        else $error("bank with reserved size code selected");

    property p_size_write;
        logic [7:0] v;
        (accWrite && selSize, v = regWriteData) |=> bankChipSizeReg == v;
    endproperty
    a_size_write: assert property (p_size_write) // RQ6
        else $error("size register did not take the written value");

    property p_size_1m_granule;
        (memReq && bankChipSizeReg[1:0] == dbmc_pkg::SIZE_1M
            && memAddr[31:26] == 6'h00 && memAddr[25:22] == windowBase[0][5:2])
            |=> (bankSelect == 4'h1 && bankChipSize == dbmc_pkg::SIZE_1M);
    endproperty
    a_size_1m_granule: assert property (p_size_1m_granule) // RQ9
        else $error("1M bank 0 not selected on 4 MB window match");

    property p_window_write;
        logic [5:0] v;
        (accWrite && selWindow[2], v = regWriteData[5:0]) |=> windowBase[2] == v;
    endproperty
    a_window_write: assert property (p_window_write) // RQ10
        else $error("window 2 did not take the written value");

    property p_window_read;
        (accRead && selWindow != 4'h0) |=> (regReadValid && regReadData[7:6] == 2'h0);
    endproperty
    a_window_read: assert property (p_window_read) // RQ10
        else $error("window reserved bits not zero on read");

    property p_window_reset_even;
        $past(reset) |-> (windowBase[0] == dbmc_pkg::RST_WINDOW0
            && windowBase[2] == dbmc_pkg::RST_WINDOW2);
    endproperty
    a_window_reset_even: assert property (p_window_reset_even) // RQ12
        else $error("window bases 0 and 2 wrong after reset");

    property p_read_pulse;
        accRead |=> regReadValid;
    endproperty
    a_read_pulse: assert property (p_read_pulse) // RQ15
        else $error("read with access open gave no answer");

    property p_idle;
        !memReq |=> (bankSelect == 4'h0 && !bankHit && bankChipSize == 2'h0);
    endproperty
    a_idle: assert property (p_idle) // RQ16
        else $error("bank selected without a request");

endmodule // dbmc_bank_map

//--- test/testbench.sv
// Self-checking bench for the DRAM bank map configuration block
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic extendedSetupAccess = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regIndex = 16'h0000;
    logic [7:0] regWriteData = 8'h00;
    logic [7:0] regReadData;
    logic regReadValid;
    logic memReq = 1'b0;
    logic [31:0] memAddr = 32'h00000000;
    logic [3:0] bankSelect;
    logic bankHit;
    logic [1:0] bankChipSize;
    int n_fail = 0;
    int check_count = 0;
    // Behavioural copy of the register contents
    logic [7:0] mSize = 8'h00;
    logic [3:0] mEn = 4'hf;
    logic [5:0] mWin [4] = '{6'h00, 6'h01, 6'h02, 6'h03};

    // Clock at 200 MHz
    always #2.5 mclk = ~mclk;

    dbmc_bank_map uut (
        .mclk(mclk), .reset(reset),
        .extendedSetupAccess(extendedSetupAccess), .regWrite(regWrite), .regRead(regRead),
        .regIndex(regIndex), .regWriteData(regWriteData), .regReadData(regReadData),
        .regReadValid(regReadValid), .memReq(memReq), .memAddr(memAddr),
        .bankSelect(bankSelect), .bankHit(bankHit), .bankChipSize(bankChipSize)
    );

    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Single comparison point
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Expected read value, reserved bits read as zero
    function automatic logic [7:0] modelRead(input logic [15:0] idx);
        modelRead = 8'h00;
        if (idx == 16'h0181) modelRead = mSize;
        if (idx == 16'h0182) modelRead = {4'h0, mEn};
        if (idx[15:2] == 14'h0061) modelRead = {2'h0, mWin[idx[1:0]]};
    endfunction

    // Expected one-hot bank, lowest matching enabled bank wins
    function automatic logic [3:0] modelSel(input logic [31:0] a);
        logic [5:0] m;
        modelSel = 4'h0;
        for (int b = 3; b >= 0; b--) begin
            case (mSize[2*b +: 2])
                2'h0: m = 6'h3f;
                2'h2: m = 6'h3c;
                2'h3: m = 6'h30;
                default: m = 6'h00;
            endcase
            if (a[31:26] == 6'h00 && m != 6'h00 && ((a[25:20] ^ mWin[b]) & m) == 6'h00
                && (b < 2 || ((mEn >> (2 * b - 4)) & 4'h3) == 4'h0)) modelSel = 4'h1 << b;
        end
    endfunction

    // Register write, applied to the model only when access is open
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, input logic acc);
        @(posedge mclk) #1;
        extendedSetupAccess = acc;
        regWrite = 1'b1;
        regIndex = idx;
        regWriteData = d;
        @(posedge mclk) #1;
        regWrite = 1'b0;
        extendedSetupAccess = 1'b0;
        if (acc && idx == 16'h0181) mSize = d;
        if (acc && idx == 16'h0182) mEn = d[3:0];
        if (acc && idx[15:2] == 14'h0061) mWin[idx[1:0]] = d[5:0];
    endtask

    // Register read, answer one cycle after the strobe
    task automatic rd(input logic [15:0] idx, input logic acc);
        @(posedge mclk) #1;
        extendedSetupAccess = acc;
        regRead = 1'b1;
        regIndex = idx;
        @(posedge mclk) #1;
        regRead = 1'b0;
        extendedSetupAccess = 1'b0;
        chk("regReadValid", regReadValid, acc);
        if (acc) chk("regReadData", regReadData, modelRead(idx));
    endtask

    // One memory request, called at edge plus delay; back to back calls keep memReq up
    task automatic mem(input logic [31:0] a);
        logic [3:0] e;
        logic [1:0] s;
        e = modelSel(a);
        s = 2'h0;
        for (int b = 0; b < 4; b++) if (e[b]) s = mSize[2*b +: 2];
        memReq = 1'b1;
        memAddr = a;
        @(posedge mclk) #1;
        chk("bankSelect", bankSelect, e);
        chk("bankHit", bankHit, e != 4'h0);
        chk("bankChipSize", bankChipSize, s);
    endtask

    // Hang guard
    initial begin
        #200000;
        n_fail++;
        complete_run();
    end

    // Main sequence
    initial begin
        logic [15:0] idx;
        logic [31:0] a;
        void'($urandom(5));
        repeat (8) @(posedge mclk);
        #1 reset = 1'b0;
        chk("bankSelect in reset", bankSelect, 4'h0);
        // Reset contents, including the unmapped index
        for (int i = 16'h0181; i <= 16'h0187; i++) rd(i[15:0], 1'b1);
        // Reset map: banks 0 and 1 live, 2 and 3 disabled
        for (int i = 0; i < 5; i++) mem(32'h00100000 * i);
        memReq = 1'b0;
        @(posedge mclk) #1;
        chk("idle bankHit", bankHit, 1'b0);
        // Writes and reads with access closed are ignored
        wr(16'h0182, 8'h00, 1'b0);
        rd(16'h0182, 1'b0);
        rd(16'h0182, 1'b1);
        // Every enable code on banks 2 and 3
        for (int c = 0; c < 16; c++) begin
            wr(16'h0182, {4'h5, c[3:0]}, 1'b1);
            rd(16'h0182, 1'b1);
            mem(32'h00200000);
            mem(32'h00300000);
        end
        // Equal 1M chips at 0, 4, 8 and 12 MB, only bits 5:2 of each window set
        wr(16'h0182, 8'h00, 1'b1);
        wr(16'h0181, 8'haa, 1'b1);
        for (int b = 0; b < 4; b++) wr(16'h0184 + 16'(b), 8'(4 * b), 1'b1);
        for (int i = 0; i < 18; i++) mem(32'h00100000 * i + 32'h0003fff0);
        memReq = 1'b0;
        // Larger chips in lower banks, packed from address zero with no holes
        wr(16'h0181, 8'h0b, 1'b1);
        wr(16'h0185, 8'h10, 1'b1);
        wr(16'h0186, 8'h14, 1'b1);
        wr(16'h0187, 8'h15, 1'b1);
        for (int i = 0; i < 24; i++) mem(32'h00100000 * i);
        memReq = 1'b0;
        // Random configurations and biased addresses
        for (int n = 0; n < 300; n++) begin
            idx = 16'h0181 + 16'($urandom % 7);
            wr(idx, 8'($urandom), 1'b1);
            rd(16'h0181 + 16'($urandom % 7), 1'b1);
            for (int k = 0; k < 6; k++) begin
                a = $urandom;
                a[25:20] = mWin[$urandom % 4] ^ 6'($urandom % 4 == 0 ? $urandom : 0);
                if ($urandom % 8 != 0) a[31:26] = 6'h00;
                mem(a);
            end
            memReq = 1'b0;
        end
        complete_run();
    end
endmodule // testbench
